// [epa_checker.sv]
// enclave page augment checker: validates, zeroes page, writes pending map entry
// Notes on behaviour
// - leaf faults with general protection unless privilege level is zero.
// - descriptor address not 32-byte aligned gives general protection fault.
// - destination address not 4 KiB aligned gives general protection fault.
// - destination outside the page cache gives page fault at destination.
// - nonzero security record pointer not 64-byte aligned gives general protection.
// - control page or linear address not 4 KiB aligned gives general protection.
// - nonzero source page field gives general protection fault.
// - busy destination: conflict exit when virtualized with extension, else general protection.
// - destination map entry already valid gives page fault at destination.
// - no security record means regular type, read, write, no execute.
// - supplied record needs zero reserved, capability, shadow type, read, write, no execute.
// - shadow stack type without enforcement enable gives general protection.
// - control page shared, destination exclusive; control unavailable gives general protection.
// - control map invalid or not control type gives page fault at control.
// - uninitialized enclave gives general protection fault.
// - linear address must lie within enclave base and base plus size.
// - shadow stack page on first or last range page gives general protection.
// - after checks pass the whole destination page is cleared.
// - first shadow stack page gets restore token at offset 0xFF8 when the shadow stack feature bit is set.
// - map entry stores attributes and address, clears flags, sets pending.
// - map entry linked to control page id and marked valid in the same single write.
// - new page stays pending until enclave accepts it.
//
// Our own choices: the address-and-strobe port.
`timescale 1ns/1ns

module epa_checker
  import epa_pkg::*;
#(
  parameter int ZERO_COUNT = ZERO_WORDS
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           reset_n,
  // request from privileged software (same clock domain)
  input  wire logic           req_valid,
  input  wire epa_req_t       req,
  input  wire epa_secrec_t    secrec,
  input  wire epa_env_t       env,
  output logic                req_ready,
  // completion
  output logic                done,
  output epa_result_t         result,
  output logic [ADDR_W-1:0]   fault_addr,
  output epa_exit_t           exit_info,
  // page cache write port
  output logic                mem_we,
  output logic [ADDR_W-1:0]   mem_addr,
  output logic [63:0]         mem_wdata,
  // page map write port
  output logic                map_we,
  output logic [ADDR_W-1:0]   map_addr,
  output epa_map_entry_t      map_entry,
  // page locks held during the operation
  output logic                dest_lock_excl,
  output logic                control_lock_shared
);

  logic        rst_meta;
  logic        rst_n;
  epa_state_t  state;
  epa_req_t    r_req;
  epa_secrec_t r_sec;
  epa_env_t    r_env;
  epa_secrec_t eff_sec;
  epa_result_t chk_res;
  logic [ADDR_W-1:0] chk_addr;
  logic [9:0]  zero_idx;
  logic        is_ss;
  logic [ADDR_W-1:0] range_end;

  function automatic logic misaligned(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] m);
    return (a & m) != '0;
  endfunction

  function automatic logic shadow_type(input logic [TYPE_W-1:0] t);
    return (t == SHADOW_STACK_FIRST_TYPE) || (t == SHADOW_STACK_REST_TYPE);
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign req_ready = (state == EPA_IDLE);

  always_comb begin
    if (r_req.security_record_addr == '0) begin
      eff_sec.reserved_nonzero = 1'b0;
      eff_sec.page_type        = REGULAR_PAGE_TYPE;
      eff_sec.rd               = 1'b1;
      eff_sec.wr               = 1'b1;
      eff_sec.ex               = 1'b0;
    end else begin
      eff_sec = r_sec;
    end
  end

  assign is_ss     = shadow_type(eff_sec.page_type);
  assign range_end = r_env.enclave_base_field + r_env.enclave_size;

  always_comb begin
    chk_res  = EPA_RES_OK;
    chk_addr = '0;
    if (r_req.priv_level != PRIV_LEVEL_OK) begin
      chk_res = EPA_RES_GP;
    end else if (misaligned(r_req.descriptor_addr, DESC_ALIGN_MASK)) begin
      chk_res = EPA_RES_GP;
    end else if (misaligned(r_req.dest_addr, PAGE_ALIGN_MASK)) begin
      chk_res = EPA_RES_GP;
    end else if (!r_env.dest_in_cache) begin
      chk_res  = EPA_RES_PF;
      chk_addr = r_req.dest_addr;
    end else if (r_req.security_record_addr != '0 &&
                 misaligned(r_req.security_record_addr, SECREC_ALIGN_MASK)) begin
      chk_res = EPA_RES_GP;
    end else if (misaligned(r_req.control_page_addr, PAGE_ALIGN_MASK) ||
                 misaligned(r_req.requested_linear_address, PAGE_ALIGN_MASK)) begin
      chk_res = EPA_RES_GP;
    end else if (r_req.source_page_field != '0) begin
      chk_res = EPA_RES_GP;
    end else if (!r_env.control_in_cache) begin
      chk_res  = EPA_RES_PF;
      chk_addr = r_req.control_page_addr;
    end else if (r_env.dest_busy) begin
      chk_res = (r_env.vm_guest && r_env.cache_virt_ext) ? EPA_RES_CONFLICT : EPA_RES_GP;
    end else if (r_env.dest_map_valid) begin
      chk_res  = EPA_RES_PF;
      chk_addr = r_req.dest_addr;
    end else if (r_req.security_record_addr != '0 &&
                 (r_sec.reserved_nonzero || !r_env.secrec_capability_bit ||
                  !shadow_type(r_sec.page_type) || !r_sec.rd || !r_sec.wr || r_sec.ex)) begin
      chk_res = EPA_RES_GP;
    end else if (is_ss && !r_env.control_flow_enforce_enable) begin
      chk_res = EPA_RES_GP;
    end else if (r_env.control_busy) begin
      chk_res = EPA_RES_GP;
    end else if (!r_env.control_map_valid || r_env.control_map_type != CONTROL_PAGE_TYPE) begin
      chk_res  = EPA_RES_PF;
      chk_addr = r_req.control_page_addr;
    end else if (!r_env.enclave_initialized) begin
      chk_res = EPA_RES_GP;
    end else if (r_req.requested_linear_address < r_env.enclave_base_field ||
                 r_req.requested_linear_address >= range_end) begin
      chk_res = EPA_RES_GP;
    end else if (is_ss && (r_req.requested_linear_address == r_env.enclave_base_field ||
                           r_req.requested_linear_address == range_end - PAGE_SIZE)) begin
      chk_res = EPA_RES_GP;
    end
  end

  // request capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_req <= '0;
      r_sec <= '0;
      r_env <= '0;
    end else if (state == EPA_IDLE && req_valid) begin
      r_req <= req;
      r_sec <= secrec;
      r_env <= env;
    end
  end

  // sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= EPA_IDLE;
      zero_idx <= '0;
    end else begin
      case (state)
        EPA_IDLE: begin
          if (req_valid) begin
            state <= EPA_CHECK;
          end
        end
        EPA_CHECK: begin
          zero_idx <= '0;
          state    <= (chk_res == EPA_RES_OK) ? EPA_ZERO : EPA_DONE;
        end
        EPA_ZERO: begin
          if (zero_idx == 10'(ZERO_COUNT - 1)) begin
            state <= EPA_TOKEN;
          end else begin
            zero_idx <= zero_idx + 10'h001;
          end
        end
        EPA_TOKEN: state <= EPA_MAP;
        EPA_MAP:   state <= EPA_DONE;
        EPA_DONE:  state <= EPA_IDLE;
        default:   state <= EPA_IDLE;
      endcase
    end
  end

  // locks held from check through the map state, released in the cycle map_we pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dest_lock_excl      <= 1'b0;
      control_lock_shared <= 1'b0;
    end else begin
      dest_lock_excl      <= (state == EPA_IDLE && req_valid) ||
                             (state inside {EPA_CHECK, EPA_ZERO, EPA_TOKEN} &&
                              !(state == EPA_CHECK && chk_res != EPA_RES_OK));
      control_lock_shared <= (state == EPA_IDLE && req_valid) ||
                             (state inside {EPA_CHECK, EPA_ZERO, EPA_TOKEN} &&
                              !(state == EPA_CHECK && chk_res != EPA_RES_OK));
    end
  end

  // page writes: zeroing then optional token
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else begin
      mem_we    <= 1'b0;
      mem_wdata <= '0;
      if (state == EPA_ZERO) begin
        mem_we   <= 1'b1;
        mem_addr <= r_req.dest_addr + {51'h0, zero_idx, 3'h0};
      end else if (state == EPA_TOKEN && r_env.shadow_stack_feature_bit &&
                   eff_sec.page_type == SHADOW_STACK_FIRST_TYPE) begin
        mem_we    <= 1'b1;
        mem_addr  <= r_req.dest_addr + {52'h0, TOKEN_OFFSET};
        mem_wdata <= (r_req.requested_linear_address + PAGE_SIZE) |
                     {63'h0, r_env.wide_mode_attribute};
      end
    end
  end

  // map entry write, single cycle, valid set in the same final write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_we    <= 1'b0;
      map_addr  <= '0;
      map_entry <= '0;
    end else begin
      map_we <= 1'b0;
      if (state == EPA_MAP) begin
        map_we   <= 1'b1;
        map_addr <= r_req.dest_addr;
        map_entry.rd                       <= eff_sec.rd;
        map_entry.wr                       <= eff_sec.wr;
        map_entry.ex                       <= eff_sec.ex;
        map_entry.page_type                <= eff_sec.page_type;
        map_entry.linear_address           <= r_req.requested_linear_address;
        map_entry.blocked                  <= 1'b0;
        map_entry.modified                 <= 1'b0;
        map_entry.permission_restrict_flag <= 1'b0;
        map_entry.pending                  <= 1'b1;
        map_entry.control_page_id          <= r_req.control_page_addr;
        map_entry.valid                    <= 1'b1;
      end
    end
  end

  // completion report
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done       <= 1'b0;
      result     <= EPA_RES_OK;
      fault_addr <= '0;
      exit_info  <= '0;
    end else begin
      done <= 1'b0;
      if (state == EPA_CHECK) begin
        result     <= chk_res;
        fault_addr <= chk_addr;
        exit_info.conflict_exit <= (chk_res == EPA_RES_CONFLICT);
        exit_info.qual_error    <= 1'b0;
        exit_info.guest_phys    <= (chk_res == EPA_RES_CONFLICT) ? r_env.dest_guest_phys : '0;
        exit_info.guest_linear  <= (chk_res == EPA_RES_CONFLICT) ? r_req.dest_addr : '0;
      end
      if (state == EPA_DONE) begin
        done <= 1'b1;
      end
    end
  end

  // no writes after a failed check
  AST_NO_WRITE_ON_FAIL: assert property (@(posedge clk) disable iff (!rst_n)
    (state == EPA_CHECK && chk_res != EPA_RES_OK) |=> (!mem_we && !map_we) [*3])
    else $error("write after failed check");

  AST_PRIV_GP: assert property (@(posedge clk) disable iff (!rst_n)
    (state == EPA_CHECK && r_req.priv_level != PRIV_LEVEL_OK) |=> result == EPA_RES_GP ##1 done)
    else $error("privilege not enforced");

  AST_DEST_PF: assert property (@(posedge clk) disable iff (!rst_n)
    (state == EPA_CHECK && chk_res == EPA_RES_PF && !r_env.dest_in_cache)
    |=> fault_addr == $past(r_req.dest_addr))
    else $error("wrong fault address");

  AST_CONFLICT: assert property (@(posedge clk) disable iff (!rst_n)
    (state == EPA_CHECK && chk_res == EPA_RES_CONFLICT)
    |=> result == EPA_RES_CONFLICT && exit_info.conflict_exit && !exit_info.qual_error &&
        exit_info.guest_linear == r_req.dest_addr && exit_info.guest_phys == r_env.dest_guest_phys)
    else $error("bad conflict exit");

  AST_ZERO_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(state) == EPA_ZERO) |-> mem_we && mem_wdata == 64'h0000_0000_0000_0000)
    else $error("page not zeroed");

  AST_MAP_PENDING: assert property (@(posedge clk) disable iff (!rst_n)
    map_we |-> map_entry.pending && !map_entry.blocked && !map_entry.modified &&
               !map_entry.permission_restrict_flag)
    else $error("map entry flags wrong");

  AST_VALID_LAST: assert property (@(posedge clk) disable iff (!rst_n)
    map_we |-> map_entry.valid && $past(state, 2) == EPA_TOKEN)
    else $error("valid not last");

  AST_LOCK_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    mem_we |-> dest_lock_excl && control_lock_shared)
    else $error("lock not held");

  AST_DEFAULT_ATTR: assert property (@(posedge clk) disable iff (!rst_n)
    (map_we && r_req.security_record_addr == '0)
    |-> map_entry.page_type == REGULAR_PAGE_TYPE && map_entry.rd && map_entry.wr && !map_entry.ex)
    else $error("default attributes wrong");

  // token only for a supported first shadow stack page
  AST_TOKEN_GATED: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(state) == EPA_TOKEN && mem_we)
    |-> r_env.shadow_stack_feature_bit && eff_sec.page_type == SHADOW_STACK_FIRST_TYPE &&
        mem_addr == r_req.dest_addr + {52'h0, TOKEN_OFFSET})
    else $error("token write not allowed");

  COV_SUCCESS: cover property (@(posedge clk) disable iff (!rst_n) map_we);
  COV_PF: cover property (@(posedge clk) disable iff (!rst_n) done && result == EPA_RES_PF);
  COV_GP: cover property (@(posedge clk) disable iff (!rst_n) done && result == EPA_RES_GP);
  COV_CONFLICT: cover property (@(posedge clk) disable iff (!rst_n) done && result == EPA_RES_CONFLICT);
  COV_TOKEN: cover property (@(posedge clk) disable iff (!rst_n) mem_we && mem_wdata != 64'h0000_0000_0000_0000);

endmodule

// [epa_pkg.sv]
// shared types and constants for the enclave page augment checker
package epa_pkg;

  localparam int ADDR_W = 64;
  localparam int TYPE_W = 8;

  // alignment masks (low bits that must be zero), page size, token offset and required privilege level
  localparam logic [ADDR_W-1:0] DESC_ALIGN_MASK   = 64'h0000_0000_0000_001F;
  localparam logic [ADDR_W-1:0] PAGE_ALIGN_MASK   = 64'h0000_0000_0000_0FFF;
  localparam logic [ADDR_W-1:0] SECREC_ALIGN_MASK = 64'h0000_0000_0000_003F;
  localparam logic [ADDR_W-1:0] PAGE_SIZE         = 64'h0000_0000_0000_1000;
  localparam logic [11:0]       TOKEN_OFFSET      = 12'hFF8;
  localparam logic [1:0]        PRIV_LEVEL_OK     = 2'h0;

  // page type encodings
  localparam logic [TYPE_W-1:0] REGULAR_PAGE_TYPE       = 8'h01;
  localparam logic [TYPE_W-1:0] CONTROL_PAGE_TYPE       = 8'h00;
  localparam logic [TYPE_W-1:0] SHADOW_STACK_FIRST_TYPE = 8'h05;
  localparam logic [TYPE_W-1:0] SHADOW_STACK_REST_TYPE  = 8'h06;

  // page zeroing: 4 KiB cleared as 512 words of 64 bits
  localparam int ZERO_WORDS = 512;

  typedef enum logic [1:0] {
    EPA_RES_OK       = 2'b00,
    EPA_RES_GP       = 2'b01,
    EPA_RES_PF       = 2'b10,
    EPA_RES_CONFLICT = 2'b11
  } epa_result_t;

  typedef enum logic [2:0] {
    EPA_IDLE  = 3'b000,
    EPA_CHECK = 3'b001,
    EPA_ZERO  = 3'b010,
    EPA_TOKEN = 3'b011,
    EPA_MAP   = 3'b100,
    EPA_DONE  = 3'b101
  } epa_state_t;

  // request as issued by the privileged caller
  typedef struct packed {
    logic [1:0]        priv_level;
    logic [ADDR_W-1:0] descriptor_addr;
    logic [ADDR_W-1:0] dest_addr;
    logic [ADDR_W-1:0] control_page_addr;
    logic [ADDR_W-1:0] security_record_addr;
    logic [ADDR_W-1:0] source_page_field;
    logic [ADDR_W-1:0] requested_linear_address;
  } epa_req_t;

  // security record content fetched by the caller side
  typedef struct packed {
    logic              reserved_nonzero;
    logic [TYPE_W-1:0] page_type;
    logic              rd;
    logic              wr;
    logic              ex;
  } epa_secrec_t;

  // environment state sampled with the request
  typedef struct packed {
    logic              dest_in_cache;
    logic              dest_busy;
    logic              dest_map_valid;
    logic              control_in_cache;
    logic              control_busy;
    logic              control_map_valid;
    logic [TYPE_W-1:0] control_map_type;
    logic              enclave_initialized;
    logic [ADDR_W-1:0] enclave_base_field;
    logic [ADDR_W-1:0] enclave_size;
    logic              wide_mode_attribute;
    logic              control_flow_enforce_enable;
    logic              shadow_stack_feature_bit;
    logic              secrec_capability_bit;
    logic              vm_guest;
    logic              cache_virt_ext;
    logic [ADDR_W-1:0] dest_guest_phys;
  } epa_env_t;

  // page-map entry written on success
  typedef struct packed {
    logic              valid;
    logic              pending;
    logic              blocked;
    logic              modified;
    logic              permission_restrict_flag;
    logic              rd;
    logic              wr;
    logic              ex;
    logic [TYPE_W-1:0] page_type;
    logic [ADDR_W-1:0] linear_address;
    logic [ADDR_W-1:0] control_page_id;
  } epa_map_entry_t;

  typedef struct packed {
    logic              conflict_exit;
    logic              qual_error;
    logic [ADDR_W-1:0] guest_phys;
    logic [ADDR_W-1:0] guest_linear;
  } epa_exit_t;

endpackage

// [epa_caller.sv]
// behavioural model of the privileged caller issuing page augment requests
`timescale 1ns/1ns

module epa_caller
  import epa_pkg::*;
(
  // clock
  input  wire logic         clk,
  // commands from the bench
  input  wire logic         cmd_go,
  input  wire epa_req_t     cmd_req,
  input  wire epa_secrec_t  cmd_secrec,
  input  wire epa_env_t     cmd_env,
  // request toward the checker
  input  wire logic         req_ready,
  output logic              req_valid,
  output epa_req_t          req,
  output epa_secrec_t       secrec,
  output epa_env_t          env
);
  initial begin
    req_valid = 1'b0;
    req       = '0;
    secrec    = '0;
    env       = '0;
  end

  always @(posedge clk) begin
    if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      // released lines turn to garbage so a late sample cannot match by luck
      req       <= ~req;
      secrec    <= ~secrec;
      env       <= ~env;
    end else if (cmd_go && !req_valid) begin
      req_valid <= 1'b1;
      req       <= cmd_req;
      secrec    <= cmd_secrec;
      env       <= cmd_env;
    end
  end
endmodule

// [test_enclave_page_augment_checker.sv]
// self-checking bench for the enclave page augment checker
`timescale 1ns/1ns

module test_enclave_page_augment_checker
  import epa_pkg::*;
;
  localparam int          ZC    = 4;
  localparam int          LIMIT = 4000;
  localparam logic [63:0] DST   = 64'h0000_0000_0010_0000;
  localparam logic [63:0] CTL   = 64'h0000_0000_0020_0000;
  localparam logic [63:0] BAS   = 64'h0000_0000_4000_0000;
  localparam logic [63:0] SZ    = 64'h0000_0000_0001_0000;

  logic           clk, reset_n, cmd_go, req_valid, req_ready, done;
  logic           mem_we, map_we, dest_lock_excl, control_lock_shared;
  logic [63:0]    fault_addr, mem_addr, mem_wdata, map_addr;
  epa_req_t       r, cmd_req, req;
  epa_secrec_t    s, cmd_secrec, secrec;
  epa_env_t       e, cmd_env, env;
  epa_result_t    result;
  epa_exit_t      exit_info;
  epa_map_entry_t map_entry;
  int             errors, tests_run, cycles, ntest;

  epa_caller u_epa_caller (.clk(clk), .cmd_go(cmd_go), .cmd_req(cmd_req), .cmd_secrec(cmd_secrec),
    .cmd_env(cmd_env), .req_ready(req_ready), .req_valid(req_valid), .req(req), .secrec(secrec), .env(env));

  epa_checker #(.ZERO_COUNT(ZC)) u_epa_checker (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .secrec(secrec), .env(env), .req_ready(req_ready), .done(done), .result(result),
    .fault_addr(fault_addr), .exit_info(exit_info), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .map_we(map_we), .map_addr(map_addr), .map_entry(map_entry),
    .dest_lock_excl(dest_lock_excl), .control_lock_shared(control_lock_shared));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [159:0] got, input logic [159:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t test %0d got %0h expected %0h", $time, ntest, got, exp);
    end
  endtask

  // a request that passes every check; record fields are junk since its address is zero
  task automatic dflt();
    r = '0;
    r.descriptor_addr = 64'h0000_0000_0001_0020;
    r.dest_addr = DST;
    r.control_page_addr = CTL;
    r.requested_linear_address = BAS + 64'h0000_0000_0000_2000;
    s = '1;
    e = '0;
    e.dest_in_cache = 1'b1;
    e.control_in_cache = 1'b1;
    e.control_map_valid = 1'b1;
    e.control_map_type = CONTROL_PAGE_TYPE;
    e.enclave_initialized = 1'b1;
    e.enclave_base_field = BAS;
    e.enclave_size = SZ;
    e.wide_mode_attribute = 1'b1;
    e.control_flow_enforce_enable = 1'b1;
    e.shadow_stack_feature_bit = 1'b1;
    e.secrec_capability_bit = 1'b1;
    e.dest_guest_phys = 64'h0000_0000_0abc_0000;
  endtask

  task automatic ss(input logic [TYPE_W-1:0] t);
    dflt();
    r.security_record_addr = 64'h0000_0000_0003_0040;
    s = '0;
    s.page_type = t;
    s.rd = 1'b1;
    s.wr = 1'b1;
  endtask

  // issue one request, watch the write ports until completion, then judge
  task automatic go(input epa_result_t xr, input logic [63:0] xf);
    int             n, t0, mw, mp;
    logic           lk, first;
    logic [63:0]    tok;
    epa_map_entry_t gm, xm;
    n = 0;
    t0 = 0;
    mw = 0;
    mp = 0;
    lk = 1'b0;
    tok = '0;
    gm = '0;
    cmd_req <= r;
    cmd_secrec <= s;
    cmd_env <= e;
    cmd_go <= 1'b1;
    @(posedge clk);
    cmd_go <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      if (req_valid === 1'b1 && req_ready === 1'b1) t0 = n;
      if (dest_lock_excl === 1'b1 && control_lock_shared === 1'b1) lk = 1'b1;
      if (map_we === 1'b1) begin
        mp++;
        gm = map_entry;
        chk(map_addr, r.dest_addr);
      end
      if (mem_we === 1'b1) begin
        if (mw < ZC) begin
          chk(mem_addr, r.dest_addr + 64'(mw * 8));
          chk(mem_wdata, '0);
        end else begin
          tok = mem_wdata;
          chk(mem_addr, r.dest_addr + 64'(TOKEN_OFFSET));
        end
        mw++;
      end
    end while (done !== 1'b1 && n < 200);
    chk(done, 1'b1);
    chk(result, xr);
    chk(fault_addr, xf);
    chk(n - t0, (xr == EPA_RES_OK) ? ZC + 5 : 3);
    if (xr == EPA_RES_CONFLICT) chk(exit_info, {1'b1, 1'b0, e.dest_guest_phys, r.dest_addr});
    else chk(exit_info.conflict_exit, 1'b0);
    if (xr == EPA_RES_OK) begin
      xm = '0;
      xm.valid = 1'b1;
      xm.pending = 1'b1;
      xm.linear_address = r.requested_linear_address;
      xm.control_page_id = r.control_page_addr;
      xm.rd = (r.security_record_addr == '0) ? 1'b1 : s.rd;
      xm.wr = (r.security_record_addr == '0) ? 1'b1 : s.wr;
      xm.ex = (r.security_record_addr == '0) ? 1'b0 : s.ex;
      xm.page_type = (r.security_record_addr == '0) ? REGULAR_PAGE_TYPE : s.page_type;
      first = (r.security_record_addr != '0) && (s.page_type == SHADOW_STACK_FIRST_TYPE) &&
              e.shadow_stack_feature_bit;
      chk(gm, xm);
      chk(mp, 1);
      chk(lk, 1'b1);
      chk(mw, ZC + int'(first));
      if (first) chk(tok, (r.requested_linear_address + PAGE_SIZE) | 64'(e.wide_mode_attribute));
    end else begin
      chk(mw + mp, 0);
    end
    ntest++;
    $display("test %0d finished", ntest);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      summarize();
    end
  end

  initial begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    ntest = 0;
    reset_n = 1'b0;
    cmd_go = 1'b0;
    cmd_req = '0;
    cmd_secrec = '0;
    cmd_env = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    dflt(); go(EPA_RES_OK, '0);
    dflt(); r.priv_level = 2'h3; go(EPA_RES_GP, '0);
    dflt(); r.descriptor_addr[4] = 1'b1; go(EPA_RES_GP, '0);
    dflt(); r.dest_addr[11] = 1'b1; go(EPA_RES_GP, '0);
    dflt(); e.dest_in_cache = 1'b0; go(EPA_RES_PF, DST);
    dflt(); r.security_record_addr = 64'h0000_0000_0003_0020; go(EPA_RES_GP, '0);
    dflt(); r.control_page_addr[3] = 1'b1; go(EPA_RES_GP, '0);
    dflt(); r.requested_linear_address[4] = 1'b1; go(EPA_RES_GP, '0);
    dflt(); r.source_page_field = DST; go(EPA_RES_GP, '0);
    dflt(); e.dest_busy = 1'b1; e.vm_guest = 1'b1; e.cache_virt_ext = 1'b1; go(EPA_RES_CONFLICT, '0);
    dflt(); e.dest_busy = 1'b1; e.vm_guest = 1'b1; go(EPA_RES_GP, '0);
    dflt(); e.dest_map_valid = 1'b1; go(EPA_RES_PF, DST);
    ss(SHADOW_STACK_FIRST_TYPE); go(EPA_RES_OK, '0);
    ss(SHADOW_STACK_FIRST_TYPE); e.shadow_stack_feature_bit = 1'b0; go(EPA_RES_OK, '0);
    ss(SHADOW_STACK_REST_TYPE); e.wide_mode_attribute = 1'b0; go(EPA_RES_OK, '0);
    for (int k = 0; k < 6; k++) begin
      ss(SHADOW_STACK_FIRST_TYPE);
      case (k)
        0: s.reserved_nonzero = 1'b1;
        1: e.secrec_capability_bit = 1'b0;
        2: s.page_type = REGULAR_PAGE_TYPE;
        3: s.rd = 1'b0;
        4: s.wr = 1'b0;
        default: s.ex = 1'b1;
      endcase
      go(EPA_RES_GP, '0);
    end
    ss(SHADOW_STACK_REST_TYPE); e.control_flow_enforce_enable = 1'b0; go(EPA_RES_GP, '0);
    dflt(); e.control_busy = 1'b1; go(EPA_RES_GP, '0);
    dflt(); e.control_map_valid = 1'b0; go(EPA_RES_PF, CTL);
    dflt(); e.control_map_type = REGULAR_PAGE_TYPE; go(EPA_RES_PF, CTL);
    dflt(); e.control_in_cache = 1'b0; go(EPA_RES_PF, CTL);
    dflt(); e.enclave_initialized = 1'b0; go(EPA_RES_GP, '0);
    dflt(); r.requested_linear_address = BAS - PAGE_SIZE; go(EPA_RES_GP, '0);
    dflt(); r.requested_linear_address = BAS + SZ; go(EPA_RES_GP, '0);
    dflt(); r.requested_linear_address = BAS + SZ - PAGE_SIZE; go(EPA_RES_OK, '0);
    ss(SHADOW_STACK_FIRST_TYPE); r.requested_linear_address = BAS; go(EPA_RES_GP, '0);
    ss(SHADOW_STACK_REST_TYPE); r.requested_linear_address = BAS + SZ - PAGE_SIZE; go(EPA_RES_GP, '0);
    dflt(); r.priv_level = 2'h1; e.dest_in_cache = 1'b0; go(EPA_RES_GP, '0);
    dflt(); e.dest_busy = 1'b1; e.dest_map_valid = 1'b1; go(EPA_RES_GP, '0);
    dflt(); e.dest_map_valid = 1'b1; e.control_map_valid = 1'b0; go(EPA_RES_PF, DST);
    summarize();
  end
endmodule
